// >>> design/btsl_defs.vh
// Constants shared by the boot table section loader files
`ifndef BTSL_DEFS_VH
`define BTSL_DEFS_VH

// Boot-select pin codes
`define BTSL_M_SPI24      4'h1
`define BTSL_M_USB        4'h2
`define BTSL_M_SPI16      4'h9
`define BTSL_M_PAR16      4'hB
`define BTSL_M_STD16      4'hE
`define BTSL_M_STD8       4'hF
`define BTSL_M_HOST_MUX   4'h5
`define BTSL_M_HOST_NMUX  4'h6

// Field geometry
`define BTSL_ADDR_W       24
`define BTSL_LAST_B32     2'h3
`define BTSL_LAST_B16     2'h1
`define BTSL_DELAY_TAG    16'hFFFF

// Misc reset and step values
`define BTSL_ZERO24       24'h000000
`define BTSL_ONE24        24'h000001
`define BTSL_ONE16        16'h0001
`define BTSL_ONE32        32'h00000001

`endif

// >>> design/btsl_buf.v
// Two-entry valid/ready buffer between section copier and memory port
module btsl_buf #(
   parameter W = 32                    // Entry width
) (
   input  wire         clock_i,        // System clock
   input  wire         rst_n_i,        // Async reset, active low
   input  wire         in_valid_i,     // Writer offers entry
   input  wire [W-1:0] in_data_i,      // Entry offered
   output wire         in_ready_o,     // Room for an entry
   output wire         out_valid_o,    // Entry available
   output wire [W-1:0] out_data_o,     // Oldest entry
   input  wire         out_ready_i     // Reader takes entry
);
   reg [W-1:0] mem [0:1];
   reg         wr_ptr;
   reg         rd_ptr;
   reg [1:0]   fill;

   wire push = in_valid_i & in_ready_o;
   wire pop  = out_valid_o & out_ready_i;

   // Full only at two, so a stalled reader really backs up the writer
   assign in_ready_o  = (fill != 2'h2);
   assign out_valid_o = (fill != 2'h0);
   assign out_data_o  = mem[rd_ptr];

   // Storage itself needs no reset; fill count guards every read
   always @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and occupancy
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fill   <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push & ~pop) begin
            fill <= fill + 2'h1;
         end else if (pop & ~push) begin
            fill <= fill - 2'h1;
         end
      end
   end
endmodule

// >>> design/btsl_loader.v
// Boot table parser and section copier
`include "btsl_defs.vh"

// How it works
// - Odd section start address: one leading pad byte is dropped.
// - Section ending on even byte address: one trailing pad byte dropped.
// - Only true section bytes reach memory, each at its true address.
// - Section record is 32-bit byte count then 32-bit destination.
// - Count and destination use only their low 24 bits.
// - Section bytes are written sequentially from the destination address.
// - Sections repeat until a zero byte count ends the table.
// - At table end the entry point is presented and branch is signalled.
// - Program and data sections share one byte-addressed copy path.
// - Pins 0001, 1001, 0010 select byte-wide table streams.
// - Pins 1011 select 16-bit parallel word table stream.
// - Pins 1110 select 16-bit, 1111 select 8-bit serial stream.
// - Host-port modes parse no table at all.
// - Count of config entries, each 16-bit port address and value.
// - Port address FFFFh means delay of the next 16-bit cycle count.
module btsl_loader #(
   parameter AW = `BTSL_ADDR_W         // Memory address width
) (
   input  wire          clock_i,       // System clock, 100 MHz
   input  wire          rst_n_i,       // Async reset, active low
   input  wire [3:0]    boot_select_pins_i, // Boot mode straps
   input  wire          in_valid_i,    // Table stream word valid
   input  wire [15:0]   in_data_i,     // Table word, bytes in [7:0] if 8-bit
   output wire          in_ready_o,    // Loader takes table word
   output wire          mem_valid_o,   // Memory byte write request
   output wire [AW-1:0] mem_addr_o,    // Memory byte address
   output wire [7:0]    mem_data_o,    // Memory byte data
   input  wire          mem_ready_i,   // Memory accepts byte
   output reg           port_wr_o,     // Port register write pulse
   output reg  [15:0]   port_addr_o,   // Port register address
   output reg  [15:0]   port_data_o,   // Port register value
   output reg           delay_busy_o,  // Programmed delay running
   output reg           host_port_mode_o, // Host port interface boot
   output reg           mode_error_o,  // Strap code not supported
   output reg           branch_o,      // One-cycle branch pulse
   output reg           boot_done_o,   // Table fully loaded
   output reg  [AW-1:0] entry_addr_o   // Entry-point byte address
);
   // One-hot parser states
   localparam S_SAMPLE = 14'h0001;
   localparam S_ENTRY  = 14'h0002;
   localparam S_CCNT   = 14'h0004;
   localparam S_CADDR  = 14'h0008;
   localparam S_CVAL   = 14'h0010;
   localparam S_DELAY  = 14'h0020;
   localparam S_SCNT   = 14'h0040;
   localparam S_SADDR  = 14'h0080;
   localparam S_LPAD   = 14'h0100;
   localparam S_DATA   = 14'h0200;
   localparam S_TPAD   = 14'h0400;
   localparam S_DRAIN  = 14'h0800;
   localparam S_RUN    = 14'h1000;
   localparam S_HALT   = 14'h2000;

   // Strap decode: does this code carry a boot table
   function is_table;
      input [3:0] m;
      begin
         is_table = (m == `BTSL_M_SPI24) | (m == `BTSL_M_SPI16) |
                    (m == `BTSL_M_USB)   | (m == `BTSL_M_PAR16) |
                    (m == `BTSL_M_STD16) | (m == `BTSL_M_STD8);
      end
   endfunction

   // Strap decode: does the stream deliver 16-bit words
   function is_wide;
      input [3:0] m;
      begin
         is_wide = (m == `BTSL_M_PAR16) | (m == `BTSL_M_STD16);
      end
   endfunction

   function is_host;
      input [3:0] m;
      begin
         is_host = (m == `BTSL_M_HOST_MUX) | (m == `BTSL_M_HOST_NMUX);
      end
   endfunction

   reg  [13:0]   state;
   reg  [13:0]   next_state;
   reg           wide;
   reg  [7:0]    lo_byte;
   reg           lo_pend;
   reg  [31:0]   field;
   reg  [1:0]    bcnt;
   reg  [31:0]   cfg_left;
   reg  [15:0]   delay_left;
   reg  [AW-1:0] cur_addr;
   reg  [AW-1:0] left;
   wire          buf_ready;
   wire          buf_valid_out;
   wire [AW+7:0] buf_out;

   // Byte source: wide words split high byte first, low byte held back
   wire       byte_valid = lo_pend | in_valid_i;
   wire [7:0] byte_data  = lo_pend ? lo_byte :
                           (wide ? in_data_i[15:8] : in_data_i[7:0]);

   // States that consume bytes; copying stalls on a full buffer
   wire want = (state == S_ENTRY) | (state == S_CCNT) |
               (state == S_CADDR) | (state == S_CVAL) |
               (state == S_SCNT)  | (state == S_SADDR) |
               (state == S_LPAD)  | (state == S_TPAD) |
               ((state == S_DATA) & buf_ready);
   wire take = want & byte_valid;
   assign in_ready_o = want & ~lo_pend;

   // Field assembly, most significant byte first
   wire [31:0] fnext   = {field[23:0], byte_data};
   wire        is16    = (state == S_CADDR) | (state == S_CVAL);
   wire        f_last  = (bcnt == (is16 ? `BTSL_LAST_B16 : `BTSL_LAST_B32));
   wire        f_done  = take & f_last;
   // At the value's last byte the port address sits in the upper half
   wire [15:0] cfg_port = fnext[31:16];

   // Section header values trimmed to the address range
   wire [AW-1:0] f_low   = fnext[AW-1:0];
   wire          last_by = (left == `BTSL_ONE24);
   // Trailing pad present when the final true byte sits on an even address
   wire          tail_pad = ~cur_addr[0];

   // Payload bytes only; pads never reach the buffer
   wire buf_push = (state == S_DATA) & take;

   btsl_buf #(
      .W (AW + 8)
   ) u_buf (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (buf_push),
      .in_data_i   ({cur_addr, byte_data}),
      .in_ready_o  (buf_ready),
      .out_valid_o (buf_valid_out),
      .out_data_o  (buf_out),
      .out_ready_i (mem_ready_i)
   );

   assign mem_valid_o = buf_valid_out;
   assign mem_addr_o  = buf_out[AW+7:8];
   assign mem_data_o  = buf_out[7:0];

   // Next-state decode
   always @* begin
      next_state = state;
      case (state)
         S_SAMPLE: begin
            if (is_host(boot_select_pins_i)) begin
               next_state = S_RUN;
            end else if (is_table(boot_select_pins_i)) begin
               next_state = S_ENTRY;
            end else begin
               next_state = S_HALT;
            end
         end
         S_ENTRY: begin
            if (f_done) begin
               next_state = S_CCNT;
            end
         end
         S_CCNT: begin
            if (f_done) begin
               next_state = (fnext == 32'h0) ? S_SCNT : S_CADDR;
            end
         end
         S_CADDR: begin
            if (f_done) begin
               next_state = S_CVAL;
            end
         end
         S_CVAL: begin
            if (f_done) begin
               if ((cfg_port == `BTSL_DELAY_TAG) &&
                   (fnext[15:0] != 16'h0)) begin
                  next_state = S_DELAY;
               end else if (cfg_left == `BTSL_ONE32) begin
                  next_state = S_SCNT;
               end else begin
                  next_state = S_CADDR;
               end
            end
         end
         S_DELAY: begin
            if (delay_left == `BTSL_ONE16) begin
               next_state = (cfg_left == 32'h0) ? S_SCNT : S_CADDR;
            end
         end
         S_SCNT: begin
            if (f_done) begin
               next_state = (f_low == `BTSL_ZERO24) ? S_DRAIN : S_SADDR;
            end
         end
         S_SADDR: begin
            if (f_done) begin
               next_state = fnext[0] ? S_LPAD : S_DATA;
            end
         end
         S_LPAD: begin
            if (take) begin
               next_state = S_DATA;
            end
         end
         S_DATA: begin
            if (take && last_by) begin
               next_state = tail_pad ? S_TPAD : S_SCNT;
            end
         end
         S_TPAD: begin
            if (take) begin
               next_state = S_SCNT;
            end
         end
         S_DRAIN: begin
            // Branch only once every byte has landed in memory
            if (!buf_valid_out) begin
               next_state = S_RUN;
            end
         end
         S_RUN: begin
            next_state = S_RUN;
         end
         S_HALT: begin
            next_state = S_HALT;
         end
         default: begin
            next_state = S_HALT;
         end
      endcase
   end

   // Parser registers
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state      <= S_SAMPLE;
         wide       <= 1'b0;
         lo_byte    <= 8'h00;
         lo_pend    <= 1'b0;
         field      <= 32'h0;
         bcnt       <= 2'h0;
         cfg_left   <= 32'h0;
         delay_left <= 16'h0;
         cur_addr   <= `BTSL_ZERO24;
         left       <= `BTSL_ZERO24;
      end else begin
         state <= next_state;
         // Straps are caught on the first edge after reset release
         if (state == S_SAMPLE) begin
            wide <= is_wide(boot_select_pins_i);
         end
         // Low half of a wide word waits for the next byte slot
         if (take) begin
            if (lo_pend) begin
               lo_pend <= 1'b0;
            end else if (wide) begin
               lo_pend <= 1'b1;
               lo_byte <= in_data_i[7:0];
            end
         end
         // Only header states advance the field counter
         if (take && (state != S_DATA) && (state != S_LPAD) &&
             (state != S_TPAD)) begin
            field <= fnext;
            bcnt  <= f_last ? 2'h0 : bcnt + 2'h1;
         end
         if ((state == S_CCNT) && f_done) begin
            cfg_left <= fnext;
         end
         if ((state == S_CVAL) && f_done) begin
            cfg_left <= cfg_left - `BTSL_ONE32;
            if (cfg_port == `BTSL_DELAY_TAG) begin
               delay_left <= fnext[15:0];
            end
         end
         if (state == S_DELAY) begin
            delay_left <= delay_left - `BTSL_ONE16;
         end
         if ((state == S_SCNT) && f_done) begin
            left <= f_low;
         end
         if ((state == S_SADDR) && f_done) begin
            cur_addr <= f_low;
         end
         // One address step per payload byte, for code and data alike
         if (buf_push) begin
            cur_addr <= cur_addr + `BTSL_ONE24;
            left     <= left - `BTSL_ONE24;
         end
      end
   end

   // Status and side-effect outputs
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port_wr_o        <= 1'b0;
         port_addr_o      <= 16'h0;
         port_data_o      <= 16'h0;
         delay_busy_o     <= 1'b0;
         host_port_mode_o <= 1'b0;
         mode_error_o     <= 1'b0;
         branch_o         <= 1'b0;
         boot_done_o      <= 1'b0;
         entry_addr_o     <= `BTSL_ZERO24;
      end else begin
         // Tagged delay addresses never raise the port write pulse
         port_wr_o <= (state == S_CVAL) & f_done &
                      (cfg_port != `BTSL_DELAY_TAG);
         if ((state == S_CVAL) && f_done) begin
            port_addr_o <= cfg_port;
            port_data_o <= fnext[15:0];
         end
         delay_busy_o <= (next_state == S_DELAY);
         if (state == S_SAMPLE) begin
            host_port_mode_o <= is_host(boot_select_pins_i);
         end
         mode_error_o <= (next_state == S_HALT);
         if ((state == S_ENTRY) && f_done) begin
            entry_addr_o <= f_low;
         end
         // Host mode never raises done; its entry comes from the host
         branch_o    <= (state == S_DRAIN) & (next_state == S_RUN);
         boot_done_o <= (next_state == S_RUN) & ~host_port_mode_o &
                        ~(state == S_SAMPLE);
      end
   end
endmodule

// >>> verification/btsl_loader_monitor.sv
// Concurrent checks on the loader's ports
module btsl_loader_monitor #(
   parameter AW = 24                     // Address width
) (
   input wire          clock_i,          // Clock
   input wire          rst_n_i,          // Reset, active low
   input wire          in_ready_o,       // Table word taken
   input wire          mem_valid_o,      // Byte write request
   input wire [AW-1:0] mem_addr_o,       // Byte address
   input wire [7:0]    mem_data_o,       // Byte data
   input wire          mem_ready_i,      // Memory accepts
   input wire          port_wr_o,        // Port write pulse
   input wire [15:0]   port_addr_o,      // Port address
   input wire          delay_busy_o,     // Delay running
   input wire          host_port_mode_o, // Host boot
   input wire          mode_error_o,     // Bad straps
   input wire          branch_o,         // Branch pulse
   input wire          boot_done_o,      // Load finished
   input wire [AW-1:0] entry_addr_o      // Entry point
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // Branch is a lone pulse and the done level outlives it
   sequence s_branch_then_hold;
      branch_o ##1 (!branch_o && boot_done_o)[*2];
   endsequence
   // A write offer the memory has not yet taken
   sequence s_stalled;
      mem_valid_o && !mem_ready_i;
   endsequence

   a_branch_once: assert property ($rose(boot_done_o) |-> s_branch_then_hold)
      else $error("branch pulse or done level wrong");
   a_done_sticky: assert property (boot_done_o |=> boot_done_o)
      else $error("done level dropped");
   a_branch_entry: assert property (branch_o |-> $stable(entry_addr_o))
      else $error("entry point moved at branch");
   a_mem_hold: assert property (s_stalled |=>
      mem_valid_o && $stable(mem_addr_o) && $stable(mem_data_o))
      else $error("stalled write changed");
   a_end_refuse: assert property (boot_done_o |-> !in_ready_o && !mem_valid_o)
      else $error("activity after table end");
   a_host_idle: assert property (host_port_mode_o |->
      !in_ready_o && !boot_done_o && !mem_valid_o)
      else $error("host mode parsed a table");
   a_mode_halt: assert property (mode_error_o |-> !in_ready_o && !port_wr_o)
      else $error("bad straps did not halt");
   a_delay_stall: assert property (delay_busy_o |-> !in_ready_o && !port_wr_o)
      else $error("table read during delay");
   a_port_spacing: assert property (port_wr_o |=> !port_wr_o [*3])
      else $error("port writes too close");
   a_no_delay_wr: assert property (port_wr_o |-> ~&port_addr_o)
      else $error("delay entry written to port");
endmodule

bind btsl_loader btsl_loader_monitor #(.AW(AW)) u_mon (.clock_i, .rst_n_i,
   .in_ready_o, .mem_valid_o, .mem_addr_o, .mem_data_o, .mem_ready_i,
   .port_wr_o, .port_addr_o, .delay_busy_o, .host_port_mode_o,
   .mode_error_o, .branch_o,
   .boot_done_o, .entry_addr_o);

// >>> verification/btsl_src.sv
// Table source model: offers bytes, or words high byte first, with stalls
module btsl_src (
   input  wire        clock_i,    // Clock
   input  wire        rst_n_i,    // Reset, active low
   input  wire        wide_i,     // Offer 16-bit words
   input  wire        in_ready_i, // Loader takes word
   output reg         in_valid_o, // Word offered
   output reg  [15:0] in_data_o   // Offered word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] q[$];
   logic [7:0] hi;
   integer     seed = 92;

   task push(input logic [7:0] b);
      q.push_back(b);
   endtask

   initial begin
      in_valid_o = 1'b0;
      in_data_o  = 16'h0000;
   end

   // Hold an offer until taken; idle data is inverted so nothing stale passes
   always @(posedge clock_i) begin
      if (!rst_n_i || (in_valid_o && !in_ready_i)) begin
         in_valid_o <= in_valid_o && rst_n_i;
      end else if (q.size() > 1 && ($random(seed) & 3) != 0) begin
         in_valid_o <= 1'b1;
         hi = q.pop_front();
         if (wide_i)
            in_data_o <= {hi, q.pop_front()};
         else
            in_data_o <= {8'h00, hi};
      end else if (q.size() == 1 && !wide_i) begin
         in_valid_o <= 1'b1;
         in_data_o  <= {8'h00, q.pop_front()};
      end else begin
         in_valid_o <= 1'b0;
         in_data_o  <= ~in_data_o;
      end
   end
endmodule

// >>> verification/btsl_loader_bench.sv
// Self-checking bench for the boot table section loader
module btsl_loader_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_i = 0, rst_n_i = 0, mem_ready_i = 0, wide = 0;
   logic [3:0]  boot_select_pins_i = 4'h0;
   wire         in_valid_i, in_ready_o, mem_valid_o, port_wr_o;
   wire         delay_busy_o, host_port_mode_o, mode_error_o;
   wire         branch_o, boot_done_o;
   wire [15:0]  in_data_i, port_addr_o, port_data_o;
   wire [23:0]  mem_addr_o, entry_addr_o;
   wire [7:0]   mem_data_o;
   integer      errors = 0, n_tests = 0, seed = 92, cycles = 0;
   integer      n_wr, n_dly, n_br;
   logic [31:0] expq[$];
   logic [3:0]  modes[9] = '{4'h1, 4'h2, 4'h9, 4'hB, 4'hE, 4'hF,
                             4'h5, 4'h6, 4'h0};

   btsl_loader i_dut (.clock_i, .rst_n_i, .boot_select_pins_i, .in_valid_i,
      .in_data_i, .in_ready_o, .mem_valid_o, .mem_addr_o, .mem_data_o,
      .mem_ready_i, .port_wr_o, .port_addr_o, .port_data_o, .delay_busy_o,
      .host_port_mode_o, .mode_error_o, .branch_o, .boot_done_o,
      .entry_addr_o);
   btsl_src i_src (.clock_i, .rst_n_i, .wide_i(wide), .in_ready_i(in_ready_o),
      .in_valid_o(in_valid_i), .in_data_o(in_data_i));

   always #5 clock_i = ~clock_i;

   function automatic logic is_table(input logic [3:0] m);
      return m inside {4'h1, 4'h2, 4'h9, 4'hB, 4'hE, 4'hF};
   endfunction

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Memory byte writes: address and data against the expected queue
   task check_mem(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: memory write %h expected %h",
                  $time, got, exp);
      end
   endtask

   // Port register writes: address and value
   task check_port(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: port write %h expected %h",
                  $time, got, exp);
      end
   endtask

   task final_report;
      if (errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task put16(input logic [15:0] v);
      i_src.push(v[15:8]);
      i_src.push(v[7:0]);
   endtask

   task put32(input logic [31:0] v);
      put16(v[31:16]);
      put16(v[15:0]);
   endtask

   // Section record with random payload; pad bytes follow start and end address parity
   task section(input logic [23:0] dest, input logic [23:0] cnt);
      logic [7:0]  b;
      logic [23:0] last;
      last = dest + cnt - 24'h000001;
      put32({8'hA5, cnt});
      put32({8'h5A, dest});
      if (dest[0]) i_src.push(8'hEE);
      for (int i = 0; i < cnt; i++) begin
         b = $random(seed);
         i_src.push(b);
         expq.push_back({dest + 24'(i), b});
      end
      if (!last[0]) i_src.push(8'h11);
   endtask

   // One boot run per strap code, with reset in front
   task run(input logic [3:0] m);
      rst_n_i <= 1'b0;
      boot_select_pins_i <= m;
      wide <= (m == 4'hB || m == 4'hE);
      repeat (12) @(posedge clock_i);
      n_wr = 0;
      n_dly = 0;
      n_br = 0;
      if (is_table(m)) begin
         put32(32'h7F012345);
         put32(32'h00000002);
         put32(32'h1C002180);
         put32(32'hFFFF0003);
         section(24'h000201, 24'h000005);
         section(24'h000300, 24'h000003);
         section(24'h000401, 24'h000002);
         section(24'h000500, 24'h000004);
         put32(32'hFF000000);
      end
      rst_n_i <= 1'b1;
      for (int k = 0; k < 2000 && boot_done_o !== 1'b1; k++)
         @(posedge clock_i);
      repeat (4) @(posedge clock_i);
      check(boot_done_o, is_table(m));
      check(host_port_mode_o, m == 4'h5 || m == 4'h6);
      check(mode_error_o, m == 4'h0);
      if (is_table(m)) begin
         check(entry_addr_o, 24'h012345);
         check(n_br, 1);
         check(n_wr, 1);
         check(n_dly, 3);
         check(expq.size(), 0);
         check(i_src.q.size(), 0);
      end
   endtask

   // Memory readiness with long stalls, and scoring of every output event
   always @(posedge clock_i) begin
      cycles++;
      mem_ready_i <= (cycles % 64 > 20) && ($random(seed) & 3) != 0;
      if (mem_valid_o && mem_ready_i)
         check_mem({mem_addr_o, mem_data_o}, expq.pop_front());
      if (port_wr_o) begin
         check_port({port_addr_o, port_data_o}, 32'h1C002180);
         n_wr++;
      end
      n_dly += delay_busy_o;
      n_br += branch_o;
      // Ceiling well above nine boot runs; a hang ends here as a failure
      if (cycles > 30000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      @(posedge clock_i);
      foreach (modes[i]) run(modes[i]);
      final_report();
   end
endmodule
